// [verilog/tal_pkg.sv]
// Package for the terminal address latch: widths, bit positions, modes.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
package tal_pkg;
    // Address and data field layout
    localparam int ADDR_W      = 5;  // Terminal address width
    localparam int DATA_ADDR_HI = 5;  // Data bit carrying address bit 4
    localparam int DATA_ADDR_LO = 1;  // Data bit carrying address bit 0
    localparam int DATA_PAR_BIT = 0;  // Data bit carrying parity
    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST   = 5'h00;
    localparam logic              PARITY_RST = 1'h1; // Odd sum at reset
    localparam logic              SRC_RST    = 1'h0; // Pins by default

    // Address together with its parity bit
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              parity;
    } tal_addr_type;

    // How the live address is being held
    typedef enum logic [1:0] {
        TAL_TRANSPARENT = 2'b00,  // Latch pin low, pins pass through
        TAL_HELD        = 2'b01   // Latch pin high, stored value used
    } tal_mode_type;
endpackage : tal_pkg
`default_nettype wire

// [verilog/tal_latch.sv]
// Terminal address select, check and latch.
// Assumes pins come from outside the clock domain; host strobes are
// single-cycle pulses from logic on clk.
// Host config levels are held steady by the host side between writes.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE_01: Source bit zero selects address pins
// RULE_02: Source bit one selects host data
// RULE_03: Even parity blocks non-broadcast responses
// RULE_04: Latch pin low passes pins through
// RULE_05: Latch pin rising edge captures pins
// RULE_06: Latch pin high updates only via sequence
// RULE_07: Sequence with pin source captures pins
// RULE_08: Data five..one address, zero parity
// RULE_09: Host enables, arms, then writes register five
// RULE_10: Host puts address in low six bits
// RULE_11: Pin source ignores write data bits
// RULE_12: Hold until next capture; reset clears source
module tal_latch
    import tal_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Board address pins
    input  wire logic                term_addr_bit4_pin,
    input  wire logic                term_addr_bit3_pin,
    input  wire logic                term_addr_bit2_pin,
    input  wire logic                term_addr_bit1_pin,
    input  wire logic                term_addr_bit0_pin,
    input  wire logic                term_addr_parity_pin,
    input  wire logic                addr_latch_control_pin,
    // Host configuration bits, already registered on clk
    input  wire logic                addr_source_wr,      // Write strobe for source bit
    input  wire logic                addr_source_wdata,   // New source bit value
    input  wire logic                enhanced_mode_enable,
    input  wire logic                latch_on_cfg5_write,
    input  wire logic                cfg5_wr,             // Write strobe, register five
    input  wire logic [15:0]         cfg5_wdata,          // Data of that write
    // Results
    output logic                     addr_source_select,
    output logic [ADDR_W-1:0]        term_addr,
    output logic                     term_addr_parity,
    output logic                     addr_parity_ok,      // Odd sum, responds to non-broadcast
    output logic                     addr_captured        // Pulse on any capture
);
    // Pin synchronisers: first stage read only by second
    tal_addr_type pins_meta;   // First sync stage of the address pins
    tal_addr_type pins_sync;   // Second stage, the only reader of the first
    logic         lat_meta;    // First sync stage of the latch pin
    logic         lat_sync;    // Synchronised latch pin level
    logic         lat_prev;    // Latch pin one cycle back, for the edge
    // Stored address, source bit and capture pulse
    tal_addr_type held;        // Latched address and parity
    tal_addr_type next_held;   // Next latched value
    logic         src;         // Source bit, high selects host data
    logic         next_src;    // Next source bit
    logic         cap;         // Capture pulse register
    logic         next_cap;    // Next capture pulse
    // Selection
    tal_mode_type mode;        // Transparent or held
    tal_addr_type live;        // Address that the outputs follow
    tal_addr_type host_val;    // Address and parity unpacked from host data
    logic         rise;        // Synchronised latch pin went low to high
    logic         seq_hit;     // Fully armed register five write
    // Output stage
    tal_addr_type next_out;    // Next output address and parity
    logic         next_ok;     // Next odd-sum flag

    // Two-flop sync of every pin; the pins may move at any moment
    // Trade-off: two cycles of pin lag buy a metastability-safe address
    always_ff @(posedge clk) begin
        // Pin bundle in address-then-parity order
        pins_meta <= {term_addr_bit4_pin, term_addr_bit3_pin, term_addr_bit2_pin,
                      term_addr_bit1_pin, term_addr_bit0_pin, term_addr_parity_pin};
        pins_sync <= pins_meta;
        lat_meta  <= addr_latch_control_pin;
        lat_sync  <= lat_meta;
        if (rst) begin
            lat_prev <= 1'h1; // No false edge when pin is tied high at reset
        end else begin
            // Edge detector follows the synchronised level
            lat_prev <= lat_sync;
        end
    end

    // Next state of source bit, held address and capture pulse
    always_comb begin
        // Host data field split into address and parity
        host_val.addr   = cfg5_wdata[DATA_ADDR_HI:DATA_ADDR_LO]; // RULE_08
        host_val.parity = cfg5_wdata[DATA_PAR_BIT];              // RULE_08
        // Edge seen in the first cycle the synchronised level is high
        rise    = lat_sync & ~lat_prev;                          // RULE_05
        // Only a fully armed sequence latches; the arming order is the host's job
        seq_hit = lat_sync & enhanced_mode_enable & latch_on_cfg5_write & cfg5_wr; // RULE_06
        // Source bit changes only on its own write strobe
        next_src  = addr_source_wr ? addr_source_wdata : src;
        // Default: keep the latch and drop the pulse
        next_held = held;  // RULE_12
        next_cap  = 1'h0;
        if (rise) begin
            // Edge capture always takes the pins
            next_held = pins_sync;                               // RULE_05
            next_cap  = 1'h1;
        end else if (seq_hit) begin
            // Host sequence: the source bit picks data or pins
            if (src) begin
                next_held = host_val;                            // RULE_02
            end else begin
                // Write data bits are don't-care here
                next_held = pins_sync;                           // RULE_07 RULE_11
            end
            next_cap = 1'h1;
        end
    end

    // Register stage; reset returns the source to the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            src  <= SRC_RST;                                     // RULE_12
            held <= '{addr: ADDR_RST, parity: PARITY_RST};
            cap  <= 1'h0;
        end else begin
            // Normal operation
            src  <= next_src;
            held <= next_held;
            cap  <= next_cap;
        end
    end

    // Mode and live address: low latch pin is transparent
    always_comb begin
        mode = lat_sync ? TAL_HELD : TAL_TRANSPARENT;
        case (mode)
            TAL_TRANSPARENT: live = pins_sync;                   // RULE_04 RULE_01
            TAL_HELD:        live = held;                        // RULE_06
            default:         live = held;  // Unused code falls back to the latch
        endcase
    end

    // Output next values: odd-sum flag follows the live address
    always_comb begin
        next_out = live;
        next_ok  = ^{live.addr, live.parity};                    // RULE_03
    end

    // Output registers; reset shows an address with odd parity
    always_ff @(posedge clk) begin
        if (rst) begin
            term_addr        <= ADDR_RST;
            term_addr_parity <= PARITY_RST;
            addr_parity_ok   <= ^{ADDR_RST, PARITY_RST};
        end else begin
            // Follow the live address one cycle later
            term_addr        <= next_out.addr;
            term_addr_parity <= next_out.parity;
            addr_parity_ok   <= next_ok;                         // RULE_03
        end
    end
    // Source bit and capture pulse straight from their flops
    assign addr_source_select = src;
    assign addr_captured      = cap;

    // Limitation: a latch pin pulse shorter than one clock may be missed,
    // since the edge is seen only on the synchronised level.
    // The outputs lag the held value by one cycle.

    // Checks on the address path
    AST_PARITY: assert property (@(posedge clk) disable iff (rst) // RULE_03
        addr_parity_ok == ^{term_addr, term_addr_parity})
        else $error("parity flag disagrees with address");
    AST_TRANSP: assert property (@(posedge clk) disable iff (rst) // RULE_04
        (!lat_sync && !$past(rst)) |=> {term_addr, term_addr_parity} == $past(pins_sync))
        else $error("transparent mode not passing pins");
    AST_EDGE: assert property (@(posedge clk) disable iff (rst) // RULE_05
        rise |=> held == $past(pins_sync) ##1 term_addr == $past(held.addr))
        else $error("rising edge did not capture pins");

    // Checks on the host sequence
    AST_HOST: assert property (@(posedge clk) disable iff (rst) // RULE_02
        (seq_hit && !rise && src) |=> held.addr == $past(cfg5_wdata[DATA_ADDR_HI:DATA_ADDR_LO]))
        else $error("host latch missed data bits");
    AST_HOSTPAR: assert property (@(posedge clk) disable iff (rst) // RULE_08
        (seq_hit && !rise && src) |=> held.parity == $past(cfg5_wdata[DATA_PAR_BIT]))
        else $error("host latch missed parity bit");
    AST_PINSEQ: assert property (@(posedge clk) disable iff (rst) // RULE_07
        (seq_hit && !rise && !src) |=> held == $past(pins_sync))
        else $error("pin-source latch wrong");
    AST_REFUSE: assert property (@(posedge clk) disable iff (rst) // RULE_06
        (cfg5_wr && !(lat_sync && enhanced_mode_enable && latch_on_cfg5_write) && !rise)
        |=> held == $past(held))
        else $error("unarmed register five write changed the latch");

    // Checks on holding, pulses and the source bit
    AST_HOLD: assert property (@(posedge clk) disable iff (rst) // RULE_12
        (!rise && !seq_hit) |=> held == $past(held))
        else $error("held address changed without capture");
    AST_RST: assert property (@(posedge clk) rst |=> !addr_source_select) // RULE_12
        else $error("source bit not cleared by reset");
    AST_HELDOUT: assert property (@(posedge clk) disable iff (rst) // RULE_06
        (lat_sync && $past(lat_sync) && !cap) |=> term_addr == $past(held.addr))
        else $error("held mode output not from latch");
    AST_CAP: assert property (@(posedge clk) disable iff (rst) // RULE_05
        (rise || seq_hit) |=> addr_captured)
        else $error("capture without capture pulse");
    AST_NOCAP: assert property (@(posedge clk) disable iff (rst) // RULE_12
        !(rise || seq_hit) |=> !addr_captured)
        else $error("capture pulse without capture");
    AST_SRCWR: assert property (@(posedge clk) disable iff (rst) // RULE_01
        addr_source_wr |=> addr_source_select == $past(addr_source_wdata))
        else $error("source bit write lost");
    AST_SRCHOLD: assert property (@(posedge clk) disable iff (rst) // RULE_12
        !addr_source_wr |=> $stable(addr_source_select))
        else $error("source bit changed without write");

    // Main scenarios
    COV_EDGE: cover property (@(posedge clk) disable iff (rst) rise);
    COV_HOST: cover property (@(posedge clk) disable iff (rst) seq_hit && src);
    COV_PINS: cover property (@(posedge clk) disable iff (rst) seq_hit && !src);
    COV_BAD:  cover property (@(posedge clk) disable iff (rst) !addr_parity_ok);
    COV_REFUSED: cover property (@(posedge clk) disable iff (rst) cfg5_wr && !seq_hit);
endmodule : tal_latch
`default_nettype wire

// [sim/tal_host_model.sv]
// Host model: config bits and register five writes for the latch.
// Assumes the bench clock; drives only at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tal_host_model (
    // Clock
    input  wire logic        clk,
    // Config outputs
    output logic             src_wr,
    output logic             src_wd,
    output logic             en,
    output logic             arm,
    output logic             wr,
    output logic [15:0]      wd
);
    initial begin
        src_wr = 0; src_wd = 0; en = 0; arm = 0; wr = 0; wd = 16'h0000;
    end
    // One-cycle source bit write
    task set_src(input logic v);
        @(negedge clk) src_wr = 1; src_wd = v;
        @(negedge clk) src_wr = 0;
    endtask : set_src
    // Latch sequence; e low leaves enable off so it is refused
    task latch(input logic [5:0] d, input logic e);
        @(negedge clk) en = e;
        @(negedge clk) arm = 1;
        @(negedge clk) wr = 1; wd = {10'h000, d};
        @(negedge clk) wr = 0; wd = ~wd; // Stale data made visible
    endtask : latch
endmodule : tal_host_model
`default_nettype wire

// [sim/tal_latch_tb_top.sv]
// Bench for the terminal address latch; pins and latch pin driven here.
// Assumes tal_pkg and tal_host_model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tal_latch_tb_top;
    import tal_pkg::*;
    logic clk = 0, rst = 1, lat = 0, src_wr, src_wd, en, arm, wr, sel, par, ok, cap;
    logic [5:0] pins = 6'h00; // Address pins then parity
    logic [15:0] wd;
    logic [ADDR_W-1:0] ta;
    int num_errors = 0, samples_checked = 0;
    int caps = 0; // Capture pulses seen at falling edges
    initial forever #4 clk = ~clk;
    tal_host_model u_host (.clk(clk), .src_wr(src_wr), .src_wd(src_wd), .en(en),
        .arm(arm), .wr(wr), .wd(wd));
    tal_latch u_dut (.clk(clk), .rst(rst), .term_addr_bit4_pin(pins[5]),
        .term_addr_bit3_pin(pins[4]), .term_addr_bit2_pin(pins[3]),
        .term_addr_bit1_pin(pins[2]), .term_addr_bit0_pin(pins[1]),
        .term_addr_parity_pin(pins[0]), .addr_latch_control_pin(lat),
        .addr_source_wr(src_wr), .addr_source_wdata(src_wd),
        .enhanced_mode_enable(en), .latch_on_cfg5_write(arm), .cfg5_wr(wr),
        .cfg5_wdata(wd), .addr_source_select(sel), .term_addr(ta),
        .term_addr_parity(par), .addr_parity_ok(ok), .addr_captured(cap));
    // Count capture pulses where they are settled
    always @(negedge clk) begin
        if (cap === 1'h1) caps++;
    end
    task check(input logic [6:0] seen, input logic [6:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // Settle past sync lag, then compare address, parity and odd-sum flag
    task expect6(input logic [5:0] e);
        repeat (6) @(negedge clk);
        check({ta, par, ok}, {e, ^e});
    endtask : expect6
    task t_reset;
        check({ta, par, ok}, 7'h03);
        check({6'h00, sel}, 7'h00);
        check(7'(caps), 7'h00);
    endtask : t_reset
    task t_transparent;
        pins = 6'h2A; expect6(6'h2A);
        pins = 6'h06; expect6(6'h06);
        pins = 6'h11; expect6(6'h11);
    endtask : t_transparent
    task t_edge;
        pins = 6'h15; repeat (4) @(negedge clk);
        lat = 1; repeat (4) @(negedge clk);
        pins = 6'h3F; expect6(6'h15);
        expect6(6'h15);
        check(7'(caps), 7'h01);
    endtask : t_edge
    task t_pin_seq;
        u_host.latch(6'h00, 1); expect6(6'h3F);
        check({ta, par, ok}, 7'h7E);
        check(7'(caps), 7'h02);
    endtask : t_pin_seq
    task t_soft;
        u_host.set_src(1); check({6'h00, sel}, 7'h01);
        pins = 6'h01; u_host.latch(6'h2C, 1); expect6(6'h2C);
        u_host.latch(6'h13, 0); expect6(6'h2C);
        check(7'(caps), 7'h03);
        @(negedge clk) rst = 1; repeat (2) @(negedge clk); rst = 0;
        check({6'h00, sel}, 7'h00);
        check({ta, par, ok}, 7'h03);
        repeat (4) @(negedge clk);
        check({ta, par, ok}, 7'h03);
        check(7'(caps), 7'h03);
    endtask : t_soft
    task stop_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        repeat (6) @(negedge clk);
        t_reset; // With the latch pin low, reset values only stand while reset is held
        rst = 0; @(negedge clk);
        t_transparent; t_edge; t_pin_seq; t_soft;
        stop_test;
    end
endmodule : tal_latch_tb_top
`default_nettype wire
